// ---- logic/rom_regs.svh ----
`ifndef ROM_REGS_SVH
`define ROM_REGS_SVH


// Configured geometry
`define ROM_WORDS         1024
`define ROM_BPW           16
`define ROM_YMUX          8
`define ROM_BANKS         1
`define ROM_ADDR_W        $clog2(`ROM_WORDS)

// Generator limits at the smallest multiplexer factor
`define YMUX_BASE         4
`define YMUX_TOP          32
`define WORDS_MIN_BASE    32
`define WORDS_MAX_BASE    1024
`define WORDS_STEP_BASE   8
`define BPW_MAX_BASE      64
`define BPW_MIN_ONE_BANK  1
`define BPW_MIN_TWO_BANK  2
`define BANKS_MAX         2

// Absolute limits
`define TOTAL_BITS_MAX    131072
`define WORDS_MAX_ABS     8192
`define BPW_MAX_ABS       128
`define ONE_BANK_BITS_MAX 65536

// Programmed contents: arbitrary mixing constants standing in for the mask
`define ROM_MIX_MUL       32'h9E37_79B9
`define ROM_MIX_XOR       32'h5A5A_0F0F
`define ROM_MIX_SHIFT     13

`endif

// ---- logic/rom_pkg.sv ----
`include "rom_regs.svh"

package rom_pkg;

  typedef logic [`ROM_ADDR_W-1:0] addr_t;
  typedef logic [`ROM_BPW-1:0]    word_t;

  // Pins of the macro sampled as one group
  typedef struct packed {
    logic  ck;
    logic  cs_n;
    logic  oe_low;
    addr_t addr;
  } port_in_t;

  typedef enum logic [1:0] {PH_STANDBY, PH_PRECHARGE, PH_ACCESS} phase_t;

  // Programmed word for one location
  function automatic word_t rom_pattern(input addr_t a);
    logic [31:0] mix;
    mix = (32'(a) * `ROM_MIX_MUL) ^ `ROM_MIX_XOR;
    mix = mix ^ (mix >> `ROM_MIX_SHIFT);
    return word_t'(mix);
  endfunction : rom_pattern

endpackage : rom_pkg

// ---- logic/rom_array.sv ----
`timescale 1ns/1ps
`include "rom_regs.svh"

module rom_array (
  input  rom_pkg::addr_t rd_addr,
  output rom_pkg::word_t rd_word
);

  rom_pkg::word_t table_w [`ROM_WORDS];
  logic           in_range;

  // One constant entry per location
  genvar i;
  generate
    for (i = 0; i < `ROM_WORDS; i++) begin : g_entry
      assign table_w[i] = rom_pkg::rom_pattern(rom_pkg::addr_t'(i));
    end
  endgenerate

  // Addresses past the last word read as zero
  assign in_range = (32'(rd_addr) < 32'(`ROM_WORDS));
  assign rd_word  = in_range ? table_w[rd_addr] : '0;

endmodule : rom_array

// ---- logic/sync_mask_rom_read.sv ----
`timescale 1ns/1ps
`include "rom_regs.svh"

module sync_mask_rom_read (
  input  logic                   CLK,
  input  logic                   RST_N,
  input  logic                   CK,
  input  logic                   CS_N,
  input  logic                   OUTPUT_ENABLE_LOW,
  input  logic [`ROM_ADDR_W-1:0] ADDR,
  output logic [`ROM_BPW-1:0]    DOUT,
  output logic                   DOUT_OE,
  output logic                   STANDBY,
  output logic                   ACCESS_BUSY,
  output logic                   CONFIG_OK
);

  // Generator parameter checks
  localparam int unsigned SCALE     = `ROM_YMUX / `YMUX_BASE;
  localparam int unsigned WORDS_MIN = `WORDS_MIN_BASE * SCALE;
  localparam int unsigned WORDS_MAX = `WORDS_MAX_BASE * SCALE;
  localparam int unsigned WORDS_STP = `WORDS_STEP_BASE * SCALE;
  localparam int unsigned BPW_MAX   = (`BPW_MAX_BASE / SCALE) * `ROM_BANKS;
  localparam int unsigned BPW_MIN   = (`ROM_BANKS == `BANKS_MAX) ? `BPW_MIN_TWO_BANK
                                                                 : `BPW_MIN_ONE_BANK;
  localparam int unsigned BITS      = `ROM_WORDS * `ROM_BPW;
  localparam int unsigned BITS_CAP  = (`ONE_BANK_BITS_MAX) * `ROM_BANKS;

  // Power of two between the smallest and largest factor
  localparam bit YMUX_OK  = (`ROM_YMUX >= `YMUX_BASE) && (`ROM_YMUX <= `YMUX_TOP)
                            && ((`ROM_YMUX & (`ROM_YMUX - 1)) == 0);
  localparam bit WORDS_OK = (`ROM_WORDS >= WORDS_MIN) && (`ROM_WORDS <= WORDS_MAX)
                            && ((`ROM_WORDS % WORDS_STP) == 0);
  localparam bit BPW_OK   = (`ROM_BPW >= BPW_MIN) && (`ROM_BPW <= BPW_MAX);
  localparam bit BANKS_OK = (`ROM_BANKS >= 1) && (`ROM_BANKS <= `BANKS_MAX)
                            && (BITS <= BITS_CAP);
  localparam bit CAP_OK   = (BITS <= `TOTAL_BITS_MAX) && (`ROM_WORDS <= `WORDS_MAX_ABS)
                            && (`ROM_BPW <= `BPW_MAX_ABS);
  localparam bit WIDTH_OK = ($bits(ADDR) == $clog2(`ROM_WORDS))
                            && ($bits(DOUT) == `ROM_BPW);
  localparam bit CFG_OK   = YMUX_OK && WORDS_OK && BPW_OK && BANKS_OK && CAP_OK && WIDTH_OK;

  rom_pkg::port_in_t pin;
  rom_pkg::phase_t   phase_reg;
  rom_pkg::phase_t   phase_next;
  rom_pkg::addr_t    addr_reg;
  rom_pkg::addr_t    addr_next;
  rom_pkg::word_t    word_reg;
  rom_pkg::word_t    word_next;
  rom_pkg::word_t    rd_word;
  rom_pkg::word_t    dout_reg;
  rom_pkg::word_t    dout_next;
  logic              gated_ck_reg;
  logic              oe_reg;
  logic              oe_next;
  logic              standby_reg;
  logic              busy_reg;
  logic              cfg_ok_reg;

  wire gated_ck;
  wire start;
  wire in_access;
  wire drive_ok;

  assign pin = '{ck: CK, cs_n: CS_N, oe_low: OUTPUT_ENABLE_LOW, addr: ADDR};

  // Chip select gates the memory clock before any edge is seen
  assign gated_ck  = pin.ck & ~pin.cs_n;
  assign start     = gated_ck & ~gated_ck_reg;
  assign in_access = start | (phase_reg == rom_pkg::PH_ACCESS);

  // Drive only in the high phase of a selected, enabled access
  assign drive_ok  = gated_ck & ~pin.oe_low & in_access;

  rom_array u_array (
    .rd_addr (pin.addr),
    .rd_word (rd_word)
  );

  // Address and word are latched at the start of each access
  assign addr_next = start ? pin.addr : addr_reg;
  assign word_next = start ? rd_word : word_reg;
  assign oe_next   = drive_ok;
  assign dout_next = drive_ok ? word_next : '0;

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      rom_pkg::PH_STANDBY: begin
        if (!pin.cs_n && pin.ck && start) begin
          phase_next = rom_pkg::PH_ACCESS;
        end else if (!pin.cs_n) begin
          phase_next = rom_pkg::PH_PRECHARGE;
        end
      end
      rom_pkg::PH_PRECHARGE: begin
        if (pin.cs_n) begin
          phase_next = rom_pkg::PH_STANDBY;
        end else if (start) begin
          phase_next = rom_pkg::PH_ACCESS;
        end
      end
      rom_pkg::PH_ACCESS: begin
        if (pin.cs_n) begin
          phase_next = rom_pkg::PH_STANDBY;
        end else if (!pin.ck) begin
          phase_next = rom_pkg::PH_PRECHARGE;
        end
      end
      // An unused code falls back to stand-by
      default: begin
        phase_next = rom_pkg::PH_STANDBY;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_reg    <= rom_pkg::PH_STANDBY;
      gated_ck_reg <= 1'b0;
      addr_reg     <= '0;
      word_reg     <= '0;
    end else begin
      phase_reg    <= phase_next;
      gated_ck_reg <= gated_ck;
      addr_reg     <= addr_next;
      word_reg     <= word_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dout_reg    <= '0;
      oe_reg      <= 1'b0;
      standby_reg <= 1'b1;
      busy_reg    <= 1'b0;
      cfg_ok_reg  <= 1'b0;
    end else begin
      dout_reg    <= dout_next;
      oe_reg      <= oe_next;
      standby_reg <= pin.cs_n;
      busy_reg    <= gated_ck & in_access;
      cfg_ok_reg  <= CFG_OK;
    end
  end

  assign DOUT        = dout_reg;
  assign DOUT_OE     = oe_reg;
  assign STANDBY     = standby_reg;
  assign ACCESS_BUSY = busy_reg;
  assign CONFIG_OK   = cfg_ok_reg;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking

  default disable iff (!RST_N);

  sequence sel_rise_s;
    gated_ck && !gated_ck_reg;
  endsequence

  sequence drive_req_s;
    sel_rise_s ##0 !OUTPUT_ENABLE_LOW;
  endsequence

  sequence high_hold_s;
    (CK && !CS_N) [*2];
  endsequence

  sequence quiet_rise_s;
    sel_rise_s ##0 OUTPUT_ENABLE_LOW;
  endsequence

  sequence drive_on_s;
    DOUT_OE ##0 (CK && !CS_N && !OUTPUT_ENABLE_LOW);
  endsequence

  read_start_a : assert property (
    sel_rise_s |=> (ACCESS_BUSY && addr_reg == $past(ADDR)))
    else $error("access did not start on a selected clock rise");

  precharge_idle_a : assert property (
    !CK |=> (!DOUT_OE && !ACCESS_BUSY && DOUT == '0))
    else $error("data driven during precharge");

  standby_hold_a : assert property (
    CS_N [*2] |=> (STANDBY && !DOUT_OE && $stable(addr_reg)))
    else $error("deselected memory still active");

  gate_block_a : assert property (
    (CK && CS_N) |=> (!ACCESS_BUSY && $stable(word_reg)))
    else $error("clock passed while chip select high");

  drive_only_a : assert property (
    DOUT_OE |-> ($past(CK) && !$past(CS_N) && !$past(OUTPUT_ENABLE_LOW)))
    else $error("outputs driven outside the enable window");

  read_drive_a : assert property (
    drive_req_s |=> (DOUT_OE && DOUT == rom_pkg::rom_pattern($past(ADDR))))
    else $error("word at access start is wrong");

  data_match_a : assert property (
    (DOUT_OE && 32'(addr_reg) < 32'(`ROM_WORDS))
      |-> DOUT == rom_pkg::rom_pattern(addr_reg))
    else $error("driven word differs from programmed word");

  access_hold_a : assert property (
    sel_rise_s ##1 high_hold_s |-> ($stable(addr_reg) && ACCESS_BUSY))
    else $error("captured address moved inside one access");

  ymux_legal_a : assert property (YMUX_OK)
    else $error("illegal column multiplexer factor");

  word_range_a : assert property (WORDS_OK)
    else $error("word count outside range or step");

  bpw_range_a : assert property (BPW_OK)
    else $error("bits per word outside range");

  bank_count_a : assert property (BANKS_OK)
    else $error("bank count illegal for this size");

  capacity_a : assert property (CAP_OK)
    else $error("memory larger than allowed");

  addr_width_a : assert property (WIDTH_OK)
    else $error("port widths do not match geometry");

  // The flag is still clear at the first edge after reset, so it is checked one edge on
  config_flag_a : assert property (1'b1 |=> (CONFIG_OK == CFG_OK))
    else $error("configuration flag disagrees with the generator checks");

  // Output window
  oe_block_a : assert property (
    quiet_rise_s |=> (ACCESS_BUSY && !DOUT_OE && DOUT == '0))
    else $error("output driven with output enable high");

  drive_stand_a : assert property (
    drive_on_s |=> (DOUT_OE && $stable(DOUT)))
    else $error("driven word did not stand through the high phase");

  dout_zero_a : assert property (
    !DOUT_OE |-> (DOUT == '0))
    else $error("data seen while outputs released");

  oe_drop_a : assert property (
    OUTPUT_ENABLE_LOW |=> (!DOUT_OE && DOUT == '0))
    else $error("outputs still driven after output enable went high");

  cs_drop_a : assert property (
    CS_N |=> (DOUT == '0))
    else $error("data seen after deselect");

  // Select and clock gating
  busy_source_a : assert property (
    ACCESS_BUSY |-> ($past(CK) && !$past(CS_N)))
    else $error("access busy without a selected clock");

  standby_next_a : assert property (
    CS_N |=> (STANDBY && !ACCESS_BUSY && !DOUT_OE))
    else $error("deselect did not enter stand-by");

  select_next_a : assert property (
    !CS_N |=> !STANDBY)
    else $error("stand-by flag set while selected");

  standby_flag_a : assert property (
    (phase_reg == rom_pkg::PH_STANDBY) |-> STANDBY)
    else $error("stand-by phase without stand-by flag");

  // Phase tracking
  standby_phase_a : assert property (
    CS_N |=> (phase_reg == rom_pkg::PH_STANDBY))
    else $error("deselect did not reach the stand-by phase");

  precharge_phase_a : assert property (
    (!CK && !CS_N) |=> (phase_reg == rom_pkg::PH_PRECHARGE))
    else $error("low clock did not precharge");

  access_phase_a : assert property (
    sel_rise_s |=> (phase_reg == rom_pkg::PH_ACCESS))
    else $error("selected rise did not enter the access phase");

  busy_phase_a : assert property (
    ACCESS_BUSY |-> (phase_reg == rom_pkg::PH_ACCESS))
    else $error("access busy outside the access phase");

  busy_rise_a : assert property (
    sel_rise_s |-> !ACCESS_BUSY)
    else $error("new access began while one was in progress");

  // Word capture
  word_capture_a : assert property (
    sel_rise_s |=> (word_reg == rom_pkg::rom_pattern(addr_reg)))
    else $error("captured word differs from programmed word");

  word_hold_a : assert property (
    (gated_ck && gated_ck_reg) |=> ($stable(word_reg) && $stable(addr_reg)))
    else $error("word recaptured without a new rise");

  precharge_word_a : assert property (
    !CK |=> ($stable(word_reg) && $stable(addr_reg)))
    else $error("word captured during precharge");

endmodule : sync_mask_rom_read

// ---- sim/rom_reader.sv ----
`timescale 1ns/1ps
`include "rom_regs.svh"

// Reader logic on the far side: one CK high phase per request
module rom_reader (
  input  logic           clk,
  input  logic           req,
  input  logic           cs_n_in,
  input  logic           oe_low_in,
  input  rom_pkg::addr_t addr_in,
  input  rom_pkg::word_t dout,
  input  logic           dout_oe,
  output logic           ck,
  output logic           cs_n,
  output logic           oe_low,
  output rom_pkg::addr_t addr,
  output rom_pkg::word_t held
);
  // One bank, 16K bits: below the size that needs two banks
  initial begin
    ck = 1'b0;
    cs_n = 1'b1;
    oe_low = 1'b1;
    addr = '0;
    held = '0;
  end

  always @(posedge clk) begin
    ck <= req;
    if (req) begin
      cs_n <= cs_n_in;
      oe_low <= oe_low_in;
      addr <= addr_in;
    end else begin
      // Address wanders while the clock is low
      addr <= ~addr;
    end
    if (dout_oe) begin
      held <= dout;
    end
  end
endmodule : rom_reader

// ---- sim/sync_mask_rom_read_tb.sv ----
`timescale 1ns/1ps
`include "rom_regs.svh"

module sync_mask_rom_read_tb;
  logic           CLK = 1'b0;
  logic           RST_N = 1'b0;
  logic           req = 1'b0;
  logic           cs_in = 1'b1;
  logic           oe_in = 1'b1;
  rom_pkg::addr_t a_in = '0;
  rom_pkg::addr_t addr;
  rom_pkg::word_t dout;
  rom_pkg::word_t held;
  logic           ck, cs_n, oe_low, oe, stby, busy, cfg;
  int             num_errors = 0;
  int             checks_done = 0;
  rom_pkg::addr_t pick [5] = '{10'h000, 10'h001, 10'h3FF, 10'h155, 10'h2AA};

  always #5 CLK = ~CLK;

  rom_reader PARTNER (.clk(CLK), .req(req), .cs_n_in(cs_in), .oe_low_in(oe_in),
    .addr_in(a_in), .dout(dout), .dout_oe(oe), .ck(ck), .cs_n(cs_n),
    .oe_low(oe_low), .addr(addr), .held(held));

  sync_mask_rom_read DUT (.CLK(CLK), .RST_N(RST_N), .CK(ck), .CS_N(cs_n),
    .OUTPUT_ENABLE_LOW(oe_low), .ADDR(addr), .DOUT(dout), .DOUT_OE(oe),
    .STANDBY(stby), .ACCESS_BUSY(busy), .CONFIG_OK(cfg));

  // Mask contents as programmed, worked out independently
  function automatic rom_pkg::word_t exp_word(input rom_pkg::addr_t a);
    logic [31:0] m;
    m = (32'(a) * `ROM_MIX_MUL) ^ `ROM_MIX_XOR;
    m = m ^ (m >> `ROM_MIX_SHIFT);
    return m[`ROM_BPW-1:0];
  endfunction : exp_word

  task automatic chkb(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chkb

  task automatic chkw(input string n, input rom_pkg::word_t e, input rom_pkg::word_t g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chkw

  task automatic step;
    @(posedge CLK);
    #1;
  endtask : step

  // Returns just after the edge at which the macro sampled the clock rise
  task automatic access(input logic c, input logic o, input rom_pkg::addr_t a);
    req = 1'b1;
    cs_in = c;
    oe_in = o;
    a_in = a;
    step();
    req = 1'b0;
    step();
  endtask : access

  task automatic done(input string n);
    $display("Test %s finished, mismatches so far %0d", n, num_errors);
  endtask : done

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge CLK);
    #1;
    chkb("oe in reset", 1'b0, oe);
    chkw("dout in reset", '0, dout);
    chkb("standby in reset", 1'b1, stby);
    chkb("busy in reset", 1'b0, busy);
    chkb("config in reset", 1'b0, cfg);
    RST_N = 1'b1;
    step();
    chkb("config legal", 1'b1, cfg);
    chkb("standby idle", 1'b1, stby);
    done("reset");
    foreach (pick[i]) begin
      access(1'b0, 1'b0, pick[i]);
      chkb("oe driven", 1'b1, oe);
      chkw("read word", exp_word(pick[i]), dout);
      chkb("busy", 1'b1, busy);
      chkb("selected", 1'b0, stby);
      step();
      chkb("oe precharge", 1'b0, oe);
      chkw("dout precharge", '0, dout);
      chkb("busy precharge", 1'b0, busy);
    end
    chkw("bus holder", exp_word(pick[4]), held);
    done("reads");
    // Clock held high for three sampled edges: the word must stand throughout
    req = 1'b1;
    cs_in = 1'b0;
    oe_in = 1'b0;
    a_in = 10'h2C3;
    repeat (2) step();
    chkw("long read", exp_word(10'h2C3), dout);
    step();
    req = 1'b0;
    chkw("long hold", exp_word(10'h2C3), dout);
    chkb("long busy", 1'b1, busy);
    step();
    chkb("long oe", 1'b1, oe);
    chkw("long last", exp_word(10'h2C3), dout);
    step();
    chkb("long drop", 1'b0, oe);
    chkw("long dout drop", '0, dout);
    done("long high phase");
    access(1'b0, 1'b1, 10'h0AA);
    chkb("busy oe high", 1'b1, busy);
    chkb("oe off", 1'b0, oe);
    chkw("dout off", '0, dout);
    step();
    done("output disable");
    access(1'b1, 1'b0, 10'h0AA);
    chkb("standby", 1'b1, stby);
    chkb("busy gated", 1'b0, busy);
    chkb("oe gated", 1'b0, oe);
    step();
    done("standby");
    conclude();
  end
endmodule : sync_mask_rom_read_tb
